// >>> tdcp_pkg.sv
// Constants for the down-counting timer with PWM.
// Assumes an APB register slave with one register per aligned word.
package tdcp_pkg;
  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [2:0] IDX_COUNT = 3'h0;
  localparam logic [2:0] IDX_CTRL1 = 3'h1;
  localparam logic [2:0] IDX_CTRL2 = 3'h2;
  localparam logic [2:0] IDX_DUTY = 3'h3;
  localparam logic [2:0] IDX_PSCV = 3'h4;
  localparam logic [2:0] IDX_IRQ = 3'h5;
  localparam logic [11:0] ADDR_COUNT = 12'h000;
  localparam logic [11:0] ADDR_CTRL1 = 12'h004;
  localparam logic [11:0] ADDR_CTRL2 = 12'h008;
  localparam logic [11:0] ADDR_DUTY = 12'h00c;
  localparam logic [11:0] ADDR_PSCV = 12'h010;
  localparam logic [11:0] ADDR_IRQ = 12'h014;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int C1_EN = 0;
  localparam int C1_RELOAD = 1;
  localparam int C1_ONESHOT = 2;
  localparam int C1_PWM_AL = 6;
  localparam int C1_PWM_OE = 7;
  localparam int C2_RATE_LO = 0;
  localparam int C2_PS_DIS = 3;
  localparam int C2_EDGE = 4;
  localparam int C2_SRC = 5;
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_EN = 1;
  // ----------------------------------------
  // Reset values and counter limits
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h3f;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PSCV = 8'hff;
  localparam logic [7:0] CNT_TOP = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage

// >>> tdcp_tick_if.sv
// Tick carrier between the prescaler and the timer core.
// Assumes one clock domain.
`timescale 1ns/10ps
interface tdcp_tick_if;
  logic src_tick;
  logic ps_dis;
  logic [2:0] rate;
  logic ps_clr;
  logic out_tick;
  logic [7:0] ps_count;
  modport core (output src_tick, output ps_dis, output rate, output ps_clr,
                input out_tick, input ps_count);
  modport pre (input src_tick, input ps_dis, input rate, input ps_clr,
               output out_tick, output ps_count);
endinterface

// >>> tdcp_prescaler.sv
// Second prescaler: divides source ticks by 2 to 256.
// Assumes src_tick is a one-cycle pulse in the clk domain.
`timescale 1ns/10ps
module tdcp_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Tick carrier
  tdcp_tick_if.pre tk
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] mask;
  logic hit;

  // ----------------------------------------
  // Division select
  // ----------------------------------------
  // Counts down from all ones; a tick leaves when the masked bits wrap
  assign mask = 8'((9'h002 << tk.rate) - 9'h001);
  assign hit = tk.src_tick && ((cnt_r & mask) == 8'h00);
  assign cnt_nxt = tk.ps_clr ? tdcp_pkg::RST_PSCV :
                   (tk.src_tick && !tk.ps_dis) ? cnt_r - 8'h01 : cnt_r;
  assign tk.out_tick = tk.ps_dis ? tk.src_tick : hit;
  assign tk.ps_count = cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= tdcp_pkg::RST_PSCV;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// >>> tdcp_timer.sv
// Eight-bit down-counting timer with prescaler and PWM output.
// Assumes APB master, synchronous pins, instruction tick from the core.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module tdcp_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer sources
  input wire logic inst_tick,
  input wire logic ext_clk_pin,
  // Pin and interrupt
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic pwm_pin_out,
  output logic pwm_pin_oe,
  output logic pwm_output,
  output logic underflow_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] reload_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] duty_r;
  logic flag_r;
  logic irq_en_r;
  logic stopped_r;
  logic stopped_nxt;
  logic pwm_act_r;
  logic pwm_act_nxt;
  logic ext_prev_r;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;

  tdcp_tick_if tk ();

  tdcp_prescaler u_pre (
    .clk(clk),
    .reset_n(reset_n),
    .tk(tk)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic wr;
  logic sel_count;
  logic sel_ctrl1;
  logic sel_ctrl2;
  logic sel_duty;
  logic sel_pscv;
  logic sel_irq;
  logic mapped;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign sel_count = (paddr == tdcp_pkg::ADDR_COUNT);
  assign sel_ctrl1 = (paddr == tdcp_pkg::ADDR_CTRL1);
  assign sel_ctrl2 = (paddr == tdcp_pkg::ADDR_CTRL2);
  assign sel_duty = (paddr == tdcp_pkg::ADDR_DUTY);
  assign sel_pscv = (paddr == tdcp_pkg::ADDR_PSCV);
  assign sel_irq = (paddr == tdcp_pkg::ADDR_IRQ);
  assign mapped = sel_count || sel_ctrl1 || sel_ctrl2 || sel_duty || sel_pscv || sel_irq;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  logic t_en;
  logic reload_en;
  logic one_shot;
  logic pwm_al;
  logic pwm_oe;
  logic ps_dis;
  logic edge_fall;
  logic src_ext;
  assign t_en = ctrl1_r[tdcp_pkg::C1_EN];
  assign reload_en = ctrl1_r[tdcp_pkg::C1_RELOAD];
  assign one_shot = ctrl1_r[tdcp_pkg::C1_ONESHOT];
  assign pwm_al = ctrl1_r[tdcp_pkg::C1_PWM_AL];
  assign pwm_oe = ctrl1_r[tdcp_pkg::C1_PWM_OE];
  assign ps_dis = ctrl2_r[tdcp_pkg::C2_PS_DIS];
  assign edge_fall = ctrl2_r[tdcp_pkg::C2_EDGE];
  assign src_ext = ctrl2_r[tdcp_pkg::C2_SRC];

  // ----------------------------------------
  // Clock source and edge
  // ----------------------------------------
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  assign ext_rise = ext_clk_pin && !ext_prev_r;
  assign ext_fall = !ext_clk_pin && ext_prev_r;
  assign ext_edge = edge_fall ? ext_fall : ext_rise;
  // Ticks only pass while enabled so the prescaler also freezes
  assign tk.src_tick = t_en && !stopped_r && (src_ext ? ext_edge : inst_tick);
  assign tk.ps_dis = ps_dis;
  assign tk.rate = ctrl2_r[tdcp_pkg::C2_RATE_LO +: 3];
  // Prescaler restarts on disable so a rate change begins clean
  assign tk.ps_clr = ps_dis;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic dec;
  logic uflow;
  logic count_wr;
  assign dec = tk.out_tick;
  assign uflow = dec && (count_r == tdcp_pkg::CNT_ZERO);
  assign count_wr = wr && sel_count;
  assign count_nxt = count_wr ? pwdata[7:0] :
                     !uflow ? (dec ? count_r - 8'h01 : count_r) :
                     one_shot ? count_r :
                     reload_en ? reload_r :
                     tdcp_pkg::CNT_TOP;
  assign stopped_nxt = count_wr ? 1'b0 : (stopped_r || (uflow && one_shot));

  // ----------------------------------------
  // PWM
  // ----------------------------------------
  // Active from duty match until underflow; cleared while disabled
  assign pwm_act_nxt = !t_en ? 1'b0 :
                       (uflow || count_wr) ? 1'b0 :
                       (count_r == duty_r) ? 1'b1 : pwm_act_r;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic flag_vis;
  assign flag_vis = flag_r && irq_en_r;
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (sel_count) begin
      prdata_nxt = {24'h00_0000, count_r};
    end else if (sel_ctrl1) begin
      prdata_nxt = {24'h00_0000, 5'h00, ctrl1_r[2:0]};
    end else if (sel_ctrl2) begin
      prdata_nxt = {24'h00_0000, 2'h0, ctrl2_r[5:0]};
    end else if (sel_pscv) begin
      prdata_nxt = {24'h00_0000, tk.ps_count};
    end else if (sel_irq) begin
      prdata_nxt = {30'h0000_0000, irq_en_r, flag_vis};
    end
    // Duty reads as zero, it is write-only
  end
  assign pslverr_nxt = psel && !penable && !mapped;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= tdcp_pkg::RST_COUNT;
      reload_r <= tdcp_pkg::RST_COUNT;
      stopped_r <= 1'b0;
      ext_prev_r <= 1'b0;
      pwm_act_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      if (count_wr) begin
        reload_r <= pwdata[7:0];
      end
      stopped_r <= stopped_nxt;
      ext_prev_r <= ext_clk_pin;
      pwm_act_r <= pwm_act_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_r <= tdcp_pkg::RST_CTRL1;
      ctrl2_r <= tdcp_pkg::RST_CTRL2;
      duty_r <= tdcp_pkg::RST_COUNT;
      irq_en_r <= 1'b0;
    end else begin
      if (wr && sel_ctrl1) begin
        ctrl1_r <= pwdata[7:0];
      end
      if (wr && sel_ctrl2) begin
        ctrl2_r <= {2'h0, pwdata[5:0]};
      end
      if (wr && sel_duty) begin
        duty_r <= pwdata[7:0];
      end
      if (wr && sel_irq) begin
        irq_en_r <= pwdata[tdcp_pkg::IRQ_EN];
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (uflow) begin
      flag_r <= 1'b1;
    end else if (wr && sel_irq && !pwdata[tdcp_pkg::IRQ_FLAG]) begin
      flag_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pwm_output <= 1'b0;
      pwm_pin_out <= 1'b0;
      pwm_pin_oe <= 1'b0;
      underflow_irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= prdata_nxt;
      // Error must stand with pready in the access cycle, so decode at setup
      pslverr <= psel && !penable && !mapped;
      pwm_output <= pwm_act_nxt ^ pwm_al;
      pwm_pin_out <= pwm_oe ? (pwm_act_nxt ^ pwm_al) : gpio_out;
      pwm_pin_oe <= pwm_oe ? 1'b1 : gpio_oe;
      underflow_irq <= (flag_r || uflow) && irq_en_r;
    end
  end
endmodule

// >>> tdcp_timer_asserts.sv
// Checker for the timer's APB answers, interrupt and pins.
// Assumes the ports of tdcp_timer, one clock domain.
`timescale 1ns/10ps
module tdcp_timer_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources and pins
  input wire logic inst_tick,
  input wire logic ext_clk_pin,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic pwm_pin_out,
  input wire logic pwm_pin_oe,
  input wire logic pwm_output,
  input wire logic underflow_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ---
  // Shadow of written control bits
  // ---
  logic [7:0] c1_r;
  logic ie_r;
  logic [1:0] quiet_r;
  wire wr = psel && penable && pwrite;
  wire c1_wr = wr && paddr == tdcp_pkg::ADDR_CTRL1;
  wire mapped = paddr[1:0] == 2'h0 && paddr <= tdcp_pkg::ADDR_IRQ;
  // Outputs lag a control write by two edges, so wait three
  wire settled = quiet_r == 2'h3;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c1_r <= 8'h00;
      ie_r <= 1'b0;
      quiet_r <= 2'h0;
    end else begin
      if (c1_wr) c1_r <= pwdata[7:0];
      if (wr && paddr == tdcp_pkg::ADDR_IRQ) ie_r <= pwdata[tdcp_pkg::IRQ_EN];
      quiet_r <= c1_wr ? 2'h0 : quiet_r + {1'b0, !settled};
    end
  end
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("ready missing in access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_duty_hidden: assert property (pready && !pwrite && paddr == tdcp_pkg::ADDR_DUTY |-> prdata == 32'h0)
    else $error("duty readable");
  a_irq_gated: assert property ($rose(underflow_irq) |-> ie_r)
    else $error("irq without enable");
  a_irq_off: assert property (wr && paddr == tdcp_pkg::ADDR_IRQ && !pwdata[tdcp_pkg::IRQ_EN] |-> ##2 !underflow_irq)
    else $error("irq after disable");
  a_idle_level: assert property (!c1_r[tdcp_pkg::C1_EN] && settled |-> pwm_output == c1_r[6])
    else $error("idle level wrong");
  a_pin_pwm: assert property (c1_r[7] && settled && $stable(pwm_output) |-> pwm_pin_oe && pwm_pin_out == pwm_output)
    else $error("pin not pwm");
  a_pin_gpio: assert property (!c1_r[7] && settled && $stable(gpio_out) && $stable(gpio_oe)
    |-> pwm_pin_out == gpio_out && pwm_pin_oe == gpio_oe)
    else $error("pin not gpio");
  c_irq: cover property ($rose(underflow_irq));
  c_err: cover property (pready && pslverr);
  c_pwm: cover property ($rose(pwm_output));
endmodule
bind tdcp_timer tdcp_timer_asserts u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .inst_tick, .ext_clk_pin, .gpio_out, .gpio_oe, .pwm_pin_out,
  .pwm_pin_oe, .pwm_output, .underflow_irq);

// >>> tdcp_pin_model.sv
// Far side: external clock source and load on the shared pin.
// Assumes the timer's clk; the pin has no pull resistor.
`timescale 1ns/10ps
module tdcp_pin_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic ext_clk_pin,
  input wire logic pwm_pin_out,
  input wire logic pwm_pin_oe,
  output logic pin_level
);
  logic last_r = 1'b0;
  // Released pin shows the inverse, so a stale level never passes
  assign pin_level = pwm_pin_oe ? pwm_pin_out : ~last_r;
  always_ff @(posedge clk) begin
    if (pwm_pin_oe) last_r <= pwm_pin_out;
  end
  initial ext_clk_pin = 1'b0;
  // Pin stands still between edges; hold sets slow or prompt edges
  task automatic drive_ext(input logic v, input int hold);
    @(posedge clk);
    ext_clk_pin <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// >>> tdcp_timer_tb.sv
// Testbench for the down-counting timer with PWM.
// Assumes tdcp_timer, its bound checker and the pin model.
`timescale 1ns/10ps
module tdcp_timer_tb;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ext_clk_pin, pwm_pin_out, pwm_pin_oe, pwm_output, underflow_irq, pin_level, er;
  logic inst_tick = 1'b0, gpio_out = 1'b0, gpio_oe = 1'b0;
  int fail_count = 0;
  int checked = 0;
  always #10 clk = ~clk;
  tdcp_timer u_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .inst_tick, .ext_clk_pin, .gpio_out, .gpio_oe, .pwm_pin_out, .pwm_pin_oe,
    .pwm_output, .underflow_irq);
  tdcp_pin_model u_pin (.clk, .ext_clk_pin, .pwm_pin_out, .pwm_pin_oe, .pin_level);
  task automatic stop_test();
    $display("Counts: %0d checked, %0d failed", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: no ready", $time);
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      inst_tick <= 1'b1;
      @(posedge clk);
      inst_tick <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rc(tdcp_pkg::ADDR_COUNT, 32'h0);
    rc(tdcp_pkg::ADDR_CTRL2, 32'h3f);
    rc(tdcp_pkg::ADDR_PSCV, 32'hff);
    xfer(1'b1, tdcp_pkg::ADDR_DUTY, 32'h55);
    rc(tdcp_pkg::ADDR_DUTY, 32'h0);
    rc(12'h018, 32'h0);
    cb(er, 1'b1);
    $display("reset test done");
    xfer(1'b1, tdcp_pkg::ADDR_CTRL2, 32'h08);
    xfer(1'b1, tdcp_pkg::ADDR_IRQ, 32'h02);
    xfer(1'b1, tdcp_pkg::ADDR_COUNT, 32'h05);
    rc(tdcp_pkg::ADDR_COUNT, 32'h05);
    tick(3);
    rc(tdcp_pkg::ADDR_COUNT, 32'h05);
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h01);
    tick(6);
    rc(tdcp_pkg::ADDR_COUNT, 32'hff);
    cb(underflow_irq, 1'b1);
    xfer(1'b1, tdcp_pkg::ADDR_IRQ, 32'h01);
    rc(tdcp_pkg::ADDR_IRQ, 32'h0);
    cb(underflow_irq, 1'b0);
    xfer(1'b1, tdcp_pkg::ADDR_IRQ, 32'h03);
    rc(tdcp_pkg::ADDR_IRQ, 32'h3);
    xfer(1'b1, tdcp_pkg::ADDR_IRQ, 32'h02);
    rc(tdcp_pkg::ADDR_IRQ, 32'h2);
    $display("wrap test done");
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h03);
    xfer(1'b1, tdcp_pkg::ADDR_COUNT, 32'h03);
    tick(4);
    rc(tdcp_pkg::ADDR_COUNT, 32'h03);
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h07);
    xfer(1'b1, tdcp_pkg::ADDR_COUNT, 32'h02);
    tick(5);
    rc(tdcp_pkg::ADDR_COUNT, 32'h00);
    $display("mode test done");
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h01);
    for (int r = 0; r < 8; r++) begin
      xfer(1'b1, tdcp_pkg::ADDR_CTRL2, 32'h08 | r);
      xfer(1'b1, tdcp_pkg::ADDR_CTRL2, r);
      xfer(1'b1, tdcp_pkg::ADDR_COUNT, 32'h10);
      tick((2 << r) - 1);
      rc(tdcp_pkg::ADDR_COUNT, 32'h10);
      tick(1);
      rc(tdcp_pkg::ADDR_COUNT, 32'h0f);
    end
    $display("prescaler test done");
    xfer(1'b1, tdcp_pkg::ADDR_CTRL2, 32'h28);
    rc(tdcp_pkg::ADDR_PSCV, 32'hff);
    xfer(1'b1, tdcp_pkg::ADDR_COUNT, 32'h08);
    tick(2);
    u_pin.drive_ext(1'b1, 4);
    rc(tdcp_pkg::ADDR_COUNT, 32'h07);
    u_pin.drive_ext(1'b0, 4);
    rc(tdcp_pkg::ADDR_COUNT, 32'h07);
    xfer(1'b1, tdcp_pkg::ADDR_CTRL2, 32'h38);
    u_pin.drive_ext(1'b1, 1);
    rc(tdcp_pkg::ADDR_COUNT, 32'h07);
    u_pin.drive_ext(1'b0, 1);
    rc(tdcp_pkg::ADDR_COUNT, 32'h06);
    $display("external test done");
    xfer(1'b1, tdcp_pkg::ADDR_CTRL2, 32'h08);
    xfer(1'b1, tdcp_pkg::ADDR_DUTY, 32'h02);
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h83);
    xfer(1'b1, tdcp_pkg::ADDR_COUNT, 32'h04);
    tick(1);
    cb(pwm_output, 1'b0);
    tick(1);
    cb(pwm_output, 1'b1);
    cb(pin_level, 1'b1);
    tick(3);
    cb(pwm_output, 1'b0);
    tick(2);
    cb(pwm_output, 1'b1);
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'hc3);
    tick(0);
    cb(pin_level, 1'b0);
    tick(3);
    cb(pwm_output, 1'b1);
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h43);
    for (int v = 0; v < 2; v++) begin
      gpio_out <= v[0];
      gpio_oe <= 1'b1;
      tick(0);
      cb(pin_level, v[0]);
    end
    xfer(1'b1, tdcp_pkg::ADDR_CTRL1, 32'h40);
    tick(0);
    cb(pwm_output, 1'b1);
    $display("pwm test done");
    stop_test();
  end
endmodule
